// ---- fsgic_checker.sv ----
// port checker for the frame sync generator and interrupt control block
`timescale 1ns/1ps
module fsgic_checker (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_write,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [3:0] i_gpio_in,
    input wire logic [1:0] i_port_event,
    input wire logic       o_frame_sync,
    input wire logic       o_irq
);
    logic [7:0] irq_q;
    logic [7:0] ctl_q;
    ////////////////////////////////
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) irq_q <= 8'h00;
        else if (i_reg_write && i_reg_addr == fsgic_pkg::ADDR_IRQ_CONTROL) irq_q <= i_reg_wdata;
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) ctl_q <= 8'h00;
        else if (i_reg_write && i_reg_addr == fsgic_pkg::ADDR_SYNC_CTL) ctl_q <= i_reg_wdata;
    end
    ////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence ev0_quiet;
        i_port_event[0] && irq_q[0] && irq_q[7] && !i_reg_write ##1 !i_reg_write;
    endsequence
    sequence idle_held;
        (ctl_q[0] == 1'b0 && ctl_q[7:4] == fsgic_pkg::SRC_INTERNAL && $stable(ctl_q)) [*3];
    endsequence
    sequence gpio_held;
        (ctl_q[7:4] == fsgic_pkg::SRC_GPIO0) [*4];
    endsequence
    ////////////////////////////////
    irq_gated_a: assert property (o_irq |-> $past(irq_q[7]))
        else $error("irq without global enable");
    event_irq_a: assert property (ev0_quiet |=> o_irq)
        else $error("enabled port 0 event gave no irq");
    ports_off_a: assert property ((irq_q[1:0] == 2'b00) [*2] |-> !o_irq)
        else $error("irq with both ports disabled");
    reserved_read_a: assert property (i_reg_read && i_reg_addr == 8'h1d |=> o_reg_rdata == 8'h00)
        else $error("reserved read not zero");
    rdata_hold_a: assert property (!i_reg_read |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    ctl_readback_a: assert property (i_reg_read && !i_reg_write && i_reg_addr == fsgic_pkg::ADDR_IRQ_CONTROL
        |=> o_reg_rdata == irq_q)
        else $error("irq control readback wrong");
    idle_level_a: assert property (idle_held |-> o_frame_sync == ctl_q[2])
        else $error("sync not at idle level");
    gpio_pass_a: assert property (gpio_held |-> o_frame_sync == $past(i_gpio_in[0], 3))
        else $error("gpio sync not passed");
endmodule : fsgic_checker

bind fsgic_top fsgic_checker u_fsgic_checker (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_write,
    .i_reg_wdata, .i_reg_read, .o_reg_rdata, .i_gpio_in, .i_port_event, .o_frame_sync, .o_irq);

// ---- fsgic_pkg.sv ----
// package for the frame sync generator and interrupt control block
package fsgic_pkg;

    localparam logic [7:0] ADDR_SYNC_CTL        = 8'h18;
    localparam logic [7:0] ADDR_HIGH_UPPER      = 8'h19;
    localparam logic [7:0] ADDR_HIGH_LOWER      = 8'h1a;
    localparam logic [7:0] ADDR_LOW_UPPER       = 8'h1b;
    localparam logic [7:0] ADDR_LOW_LOWER       = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CONTROL     = 8'h23;
    localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h24;
    localparam logic [7:0] RESET_BYTE           = 8'h00;

    localparam int          BIT_ONE_SHOT        = 3;
    localparam int          BIT_GLOBAL_IRQ_EN   = 7;
    localparam int          BIT_GLOBAL_IRQ_FLAG = 7;

    localparam int          SYS_CLK_HZ          = 200_000_000;
    localparam int          REF_CLK_HZ          = 25_000_000;
    localparam int          REF_DIV_CYCLES      = SYS_CLK_HZ / REF_CLK_HZ;
    localparam logic [3:0]  REF_DIV_LAST        = 4'(REF_DIV_CYCLES - 1);

    localparam logic [3:0]  SRC_PORT0           = 4'h0;
    localparam logic [3:0]  SRC_PORT1           = 4'h1;
    localparam logic [3:0]  SRC_INTERNAL        = 4'h7;
    localparam logic [3:0]  SRC_GPIO0           = 4'h8;
    localparam logic [3:0]  SRC_GPIO3           = 4'hb;

    typedef struct packed {
        logic [3:0] pulse_source_select;
        logic       one_shot_request;
        logic       pulse_idle_level;
        logic       pulse_shape_select;
        logic       pulse_generator_on;
    } fsgic_ctl_t;

    typedef struct packed {
        logic       global_irq_en;
        logic [4:0] spare;
        logic       port1_irq_enable;
        logic       port0_irq_enable;
    } fsgic_irq_ctl_t;

endpackage : fsgic_pkg

// ---- fsgic_top.sv ----
// frame sync pulse generator with period registers and interrupt enable control
`timescale 1ns/1ps
module fsgic_top (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_write,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_read,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [1:0] i_bc_frame_clk,
    input  wire logic [3:0] i_gpio_in,
    input  wire logic [1:0] i_port_event,
    input  wire logic [1:0] i_port_sts_read,
    output logic            o_frame_sync,
    output logic            o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    fsgic_pkg::fsgic_ctl_t     ctl_reg;
    fsgic_pkg::fsgic_irq_ctl_t irq_ctl_reg;
    logic [7:0]                high_upper_reg;
    logic [7:0]                high_lower_reg;
    logic [7:0]                low_upper_reg;
    logic [7:0]                low_lower_reg;
    logic [1:0]                port_flag_reg;
    logic                      shot_busy_reg;
    logic                      wr_ctl;

    assign wr_ctl = i_reg_write && (i_reg_addr == fsgic_pkg::ADDR_SYNC_CTL);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_reg        <= '0;
            irq_ctl_reg    <= '0;
            high_upper_reg <= fsgic_pkg::RESET_BYTE;
            high_lower_reg <= fsgic_pkg::RESET_BYTE;
            low_upper_reg  <= fsgic_pkg::RESET_BYTE;
            low_lower_reg  <= fsgic_pkg::RESET_BYTE;
        end else begin
            // one-shot bit self clears
            ctl_reg.one_shot_request <= 1'b0;
            if (i_reg_write) begin
                unique case (i_reg_addr)
                    fsgic_pkg::ADDR_SYNC_CTL:    ctl_reg        <= i_reg_wdata;
                    fsgic_pkg::ADDR_HIGH_UPPER:  high_upper_reg <= i_reg_wdata;
                    fsgic_pkg::ADDR_HIGH_LOWER:  high_lower_reg <= i_reg_wdata;
                    fsgic_pkg::ADDR_LOW_UPPER:   low_upper_reg  <= i_reg_wdata;
                    fsgic_pkg::ADDR_LOW_LOWER:   low_lower_reg  <= i_reg_wdata;
                    fsgic_pkg::ADDR_IRQ_CONTROL: irq_ctl_reg    <= i_reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    logic global_flag;
    logic [7:0] irq_status;
    assign global_flag = |(port_flag_reg & {irq_ctl_reg.port1_irq_enable, irq_ctl_reg.port0_irq_enable});
    assign irq_status  = {global_flag, 5'h00, port_flag_reg};

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= fsgic_pkg::RESET_BYTE;
        end else if (i_reg_read) begin
            unique case (i_reg_addr)
                fsgic_pkg::ADDR_SYNC_CTL:    o_reg_rdata <= ctl_reg;
                fsgic_pkg::ADDR_HIGH_UPPER:  o_reg_rdata <= high_upper_reg;
                fsgic_pkg::ADDR_HIGH_LOWER:  o_reg_rdata <= high_lower_reg;
                fsgic_pkg::ADDR_LOW_UPPER:   o_reg_rdata <= low_upper_reg;
                fsgic_pkg::ADDR_LOW_LOWER:   o_reg_rdata <= low_lower_reg;
                fsgic_pkg::ADDR_IRQ_CONTROL: o_reg_rdata <= irq_ctl_reg;
                fsgic_pkg::ADDR_IRQ_STATUS:  o_reg_rdata <= irq_status;
                default:                     o_reg_rdata <= fsgic_pkg::RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags
    logic [1:0] port_irq_en;
    assign port_irq_en = {irq_ctl_reg.port1_irq_enable, irq_ctl_reg.port0_irq_enable};

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    port_flag_reg[gp] <= 1'b0;
                end else if (i_port_event[gp] && port_irq_en[gp]) begin
                    port_flag_reg[gp] <= 1'b1;
                end else if (i_port_sts_read[gp]) begin
                    port_flag_reg[gp] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= global_flag && irq_ctl_reg.global_irq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference source
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [3:0] div_reg;
    logic       int_tick;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {i_gpio_in, i_bc_frame_clk};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg <= '0;
        end else if (div_reg == fsgic_pkg::REF_DIV_LAST) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign int_tick = (div_reg == fsgic_pkg::REF_DIV_LAST);

    logic       ref_tick;
    logic       ext_mode;
    logic       ext_level;
    logic [3:0] src;
    assign src       = ctl_reg.pulse_source_select;
    assign ext_mode  = (src >= fsgic_pkg::SRC_GPIO0) && (src <= fsgic_pkg::SRC_GPIO3);
    assign ext_level = sync2_reg[2 + src[1:0]];

    always_comb begin
        unique case (src)
            fsgic_pkg::SRC_PORT0:    ref_tick = sync2_reg[0] && !sync3_reg[0];
            fsgic_pkg::SRC_PORT1:    ref_tick = sync2_reg[1] && !sync3_reg[1];
            fsgic_pkg::SRC_INTERNAL: ref_tick = int_tick;
            default:                 ref_tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse generator
    logic [23:0] high_count;
    logic [23:0] low_count;
    logic [23:0] count_reg;
    logic        level_reg;
    logic        run_reg;
    logic        start_shot;

    assign high_count = ctl_reg.pulse_shape_select ? {low_upper_reg, low_lower_reg, high_lower_reg}
                                                   : {8'h00, high_upper_reg, high_lower_reg};
    assign low_count  = ctl_reg.pulse_shape_select ? {low_upper_reg, low_lower_reg, high_lower_reg}
                                                   : {8'h00, low_upper_reg, low_lower_reg};

    assign start_shot = wr_ctl && i_reg_wdata[fsgic_pkg::BIT_ONE_SHOT] && !shot_busy_reg
                        && !ctl_reg.pulse_generator_on;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg     <= '0;
            level_reg     <= 1'b0;
            run_reg       <= 1'b0;
            shot_busy_reg <= 1'b0;
        end else if (start_shot) begin
            level_reg     <= !ctl_reg.pulse_idle_level;
            count_reg     <= ctl_reg.pulse_idle_level ? low_count : high_count;
            shot_busy_reg <= 1'b1;
        end else if (shot_busy_reg) begin
            if (ref_tick) begin
                if (count_reg == 24'h000000) begin
                    level_reg     <= ctl_reg.pulse_idle_level;
                    shot_busy_reg <= 1'b0;
                end else begin
                    count_reg <= count_reg - 24'h000001;
                end
            end
        end else if (!ctl_reg.pulse_generator_on) begin
            level_reg <= ctl_reg.pulse_idle_level;
            run_reg   <= 1'b0;
        end else if (!run_reg) begin
            level_reg <= ctl_reg.pulse_idle_level;
            count_reg <= ctl_reg.pulse_idle_level ? high_count : low_count;
            run_reg   <= 1'b1;
        end else if (ref_tick) begin
            if (count_reg == 24'h000000) begin
                level_reg <= !level_reg;
                count_reg <= level_reg ? low_count : high_count;
            end else begin
                count_reg <= count_reg - 24'h000001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame_sync <= 1'b0;
        end else if (ext_mode && !shot_busy_reg) begin
            o_frame_sync <= ext_level;
        end else begin
            o_frame_sync <= level_reg;
        end
    end

endmodule : fsgic_top

// ---- tb_top.sv ----
// testbench for the frame sync generator and interrupt control block
`timescale 1ns/1ps
module tb_top;
    logic       i_clk_sys = 1'b0, i_reset_n = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [1:0] i_port_event = 2'h0, i_port_sts_read = 2'h0, i_bc_frame_clk = 2'h0;
    logic [3:0] i_gpio_in = 4'h0;
    logic       o_frame_sync, o_irq;
    int         num_errors = 0, checks = 0;
    fsgic_top u_fsgic_top (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_write, .i_reg_wdata, .i_reg_read,
        .o_reg_rdata, .i_bc_frame_clk, .i_gpio_in, .i_port_event, .i_port_sts_read, .o_frame_sync, .o_irq);
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////
    task cyc(int n); repeat (n) @(posedge i_clk_sys); #1; endtask : cyc
    task chk(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(logic [7:0] a, logic [7:0] d);
        i_reg_addr = a; i_reg_wdata = d; i_reg_write = 1'b1; cyc(1); i_reg_write = 1'b0; cyc(1);
    endtask : wr
    // one rising edge per repetition on a back-channel frame clock
    task pulse(int p, int n);
        repeat (n) begin
            i_bc_frame_clk[p] = 1'b1; cyc(2); i_bc_frame_clk[p] = 1'b0; cyc(2);
        end
    endtask : pulse
    task rd(logic [7:0] a, logic [7:0] exp);
        i_reg_addr = a; i_reg_read = 1'b1; cyc(1); i_reg_read = 1'b0; cyc(1); chk(o_reg_rdata, exp);
    endtask : rd
    task ev(int n, bit clr);
        if (clr) i_port_sts_read[n] = 1'b1; else i_port_event[n] = 1'b1;
        cyc(1); i_port_sts_read = 2'h0; i_port_event = 2'h0; cyc(2);
    endtask : ev
    task width(logic lvl, int exp);
        int n;
        for (n = 0; n < 999 && o_frame_sync !== !lvl; n++) cyc(1);
        for (n = 0; n < 999 && o_frame_sync !== lvl; n++) cyc(1);
        for (n = 0; n < 999 && o_frame_sync === lvl; n++) cyc(1);
        chk(8'(n), 8'(exp));
    endtask : width
    task stop_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    ////////////////////////////////
    task t_regs;
        for (int a = 8'h19; a <= 8'h1c; a++) rd(8'(a), 8'h00);
        rd(8'h23, 8'h00);
        wr(8'h1b, 8'ha5); rd(8'h1b, 8'ha5);
        wr(8'h19, 8'h3c); rd(8'h19, 8'h3c);
        wr(8'h1d, 8'h5a); rd(8'h1d, 8'h00);
    endtask : t_regs
    task t_gen;
        wr(8'h19, 8'h00); wr(8'h1a, 8'h01); wr(8'h1b, 8'h00); wr(8'h1c, 8'h02); wr(8'h18, 8'h71);
        width(1'b1, 16);
        width(1'b0, 24);
        wr(8'h19, 8'h05); wr(8'h1a, 8'h02); wr(8'h1c, 8'h00); wr(8'h18, 8'h73);
        width(1'b1, 24);
        width(1'b0, 24);
        wr(8'h18, 8'h74); cyc(40); chk(8'(o_frame_sync), 8'h01);
        wr(8'h18, 8'h70); cyc(3); chk(8'(o_frame_sync), 8'h00);
    endtask : t_gen
    task t_port;
        wr(8'h19, 8'h00); wr(8'h1a, 8'h01); wr(8'h1b, 8'h00); wr(8'h1c, 8'h00);
        wr(8'h18, 8'h08); chk(8'(o_frame_sync), 8'h01);
        pulse(0, 1); chk(8'(o_frame_sync), 8'h01);
        wr(8'h18, 8'h08); pulse(0, 1); chk(8'(o_frame_sync), 8'h00);
        pulse(0, 2); chk(8'(o_frame_sync), 8'h00);
        rd(8'h18, 8'h00);
        wr(8'h18, 8'h01); chk(8'(o_frame_sync), 8'h00);
        pulse(0, 1); chk(8'(o_frame_sync), 8'h01);
        pulse(0, 1); chk(8'(o_frame_sync), 8'h01);
        pulse(0, 1); chk(8'(o_frame_sync), 8'h00);
        pulse(0, 1); chk(8'(o_frame_sync), 8'h01);
        wr(8'h18, 8'h11); pulse(0, 2); chk(8'(o_frame_sync), 8'h01);
        pulse(1, 2); chk(8'(o_frame_sync), 8'h00);
        wr(8'h18, 8'h14); cyc(1); chk(8'(o_frame_sync), 8'h01);
    endtask : t_port
    task t_gpio;
        wr(8'h18, 8'h80); i_gpio_in = 4'h1; cyc(4); chk(8'(o_frame_sync), 8'h01);
        i_gpio_in = 4'he; cyc(4); chk(8'(o_frame_sync), 8'h00);
        i_gpio_in = 4'h7; wr(8'h18, 8'hb0); cyc(4); chk(8'(o_frame_sync), 8'h00);
        i_gpio_in = 4'h8; cyc(4); chk(8'(o_frame_sync), 8'h01);
    endtask : t_gpio
    task t_irq;
        wr(8'h23, 8'h81); ev(1, 0); chk(8'(o_irq), 8'h00);
        ev(0, 0); chk(8'(o_irq), 8'h01);
        rd(8'h24, 8'h81);
        wr(8'h23, 8'h01); cyc(2); chk(8'(o_irq), 8'h00);
        rd(8'h24, 8'h81);
        wr(8'h23, 8'h83); ev(0, 1); chk(8'(o_irq), 8'h00);
        ev(1, 0); chk(8'(o_irq), 8'h01);
        ev(1, 1); chk(8'(o_irq), 8'h00);
    endtask : t_irq
    ////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk_sys);
        #1 i_reset_n = 1'b1;
        t_regs;
        t_gen;
        t_port;
        t_gpio;
        t_irq;
        stop_test;
    end
    initial begin
        #50000;
        num_errors++;
        stop_test;
    end
endmodule : tb_top
